// *** rtl/cnc_regs.sv ***
// Overview of operation
// - Control bit 14 halts unit in debug; writable only in debug, else zero
// - Control clear alias clears every control bit written with one
// - Control set alias sets every control bit written with one
// - Control invert alias toggles every control bit written with one
// - Alias writes never touch unimplemented or read-only bits
// - Alias registers are write-only; their reads carry no meaning
// - Control bit 15 switches change detection on or off; status, mask and interrupt logic stay live
// - Per-pin enable bits arm change notice for input pins only
`timescale 1ns/1ps
`default_nettype none
module cnc_regs #(
  parameter int PINS = cnc_pkg::PIN_COUNT
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [cnc_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [cnc_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic      [cnc_pkg::DATA_W-1:0]  hrdata,
  output logic                             hresp,
  // Processor mode indications
  input  wire logic                        debugMode,
  input  wire logic                        idleMode,
  // Port pins and their direction, one means input
  input  wire logic [PINS-1:0]             pinIn,
  input  wire logic [PINS-1:0]             pinDirection,
  // Interrupt
  output logic                             irq
);
  import cnc_pkg::*;

  typedef struct packed {
    logic                ready;
    logic                aphValid;
    logic                aphWrite;
    logic [OFS_W-1:0]    aphAddr;
    logic [DATA_W-1:0]   rdata;
    logic                unitOn;
    logic                debugHalt;
    logic                idleHalt;
    logic [PINS-1:0]     enable;
    logic [PINS-1:0]     stat;
    logic [PINS-1:0]     mask;
    logic [PINS-1:0]     pinSync1;
    logic [PINS-1:0]     pinSync2;
    logic [PINS-1:0]     pinLast;
    logic                irq;
  } cnc_state_t;

  cnc_state_t st_q;
  cnc_state_t st_d;

  logic              dataWr;
  logic              ctrlWr;
  logic              enWr;
  logic              statWr;
  logic              maskWr;
  cnc_op_t           wrOp;
  logic [DATA_W-1:0] ctrlCur;
  logic [DATA_W-1:0] ctrlMask;
  logic [DATA_W-1:0] ctrlNext;
  logic [DATA_W-1:0] enCur;
  logic [DATA_W-1:0] enMask;
  logic [DATA_W-1:0] enNext;
  logic              unitActive;
  logic [PINS-1:0]   pinEvent;
  logic [PINS-1:0]   statClr;
  logic              aphTake;

  // True when an offset falls in the four-word alias group at base
  function automatic logic inGroup(input logic [OFS_W-1:0] a,
                                   input logic [OFS_W-1:0] base);
    inGroup = (a & GROUP_MASK) == base;
  endfunction

  function automatic logic [DATA_W-1:0] ctrlWord(input cnc_state_t s,
                                                 input logic dbg);
    ctrlWord = CTRL_RST;
    ctrlWord[UNIT_ON_BIT]    = s.unitOn;
    ctrlWord[DEBUG_HALT_BIT] = s.debugHalt & dbg;
    ctrlWord[IDLE_HALT_BIT]  = s.idleHalt;
  endfunction

  function automatic logic [DATA_W-1:0] readWord(input logic [OFS_W-1:0] a,
                                                 input cnc_state_t s,
                                                 input logic dbg);
    readWord = ALIAS_READ;
    case (a)
      CTRL_OFS: readWord = ctrlWord(s, dbg);
      EN_OFS:   readWord[PINS-1:0] = s.enable;
      STAT_OFS: readWord[PINS-1:0] = s.stat;
      MASK_OFS: readWord[PINS-1:0] = s.mask;
      default:  readWord = ALIAS_READ;
    endcase
  endfunction

  // Data phase decode of the captured address
  always_comb begin
    dataWr = st_q.aphValid & st_q.aphWrite;
    ctrlWr = dataWr & inGroup(st_q.aphAddr, CTRL_OFS);
    enWr   = dataWr & inGroup(st_q.aphAddr, EN_OFS);
    statWr = dataWr & (st_q.aphAddr == STAT_OFS);
    maskWr = dataWr & (st_q.aphAddr == MASK_OFS);
    wrOp   = cnc_op_t'(st_q.aphAddr[3:2]);
  end

  // Only implemented control bits are writable; halt-in-debug only in debug
  always_comb begin
    ctrlCur  = ctrlWord(st_q, 1'b1);
    ctrlMask = '0;
    ctrlMask[UNIT_ON_BIT]    = 1'b1;
    ctrlMask[IDLE_HALT_BIT]  = 1'b1;
    ctrlMask[DEBUG_HALT_BIT] = debugMode;
    enCur    = '0;
    enCur[PINS-1:0]  = st_q.enable;
    enMask   = '0;
    enMask[PINS-1:0] = '1;
  end

  cnc_alias_update #(
    .W     (DATA_W)
  ) ctrlAlias (
    .cur   (ctrlCur),
    .wmask (ctrlMask),
    .wdata (hwdata),
    .op    (wrOp),
    .nxt   (ctrlNext)
  );

  cnc_alias_update #(
    .W     (DATA_W)
  ) enAlias (
    .cur   (enCur),
    .wmask (enMask),
    .wdata (hwdata),
    .op    (wrOp),
    .nxt   (enNext)
  );

  // Unit runs while on and not halted by debug or idle
  always_comb begin
    unitActive = st_q.unitOn
               & ~(st_q.debugHalt & debugMode)
               & ~(st_q.idleHalt & idleMode);
    pinEvent = (st_q.pinSync2 ^ st_q.pinLast)
             & st_q.enable & pinDirection
             & {PINS{unitActive}};
    statClr  = statWr ? hwdata[PINS-1:0] : '0;
    aphTake  = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
  end

  always_comb begin
    st_d = st_q;
    st_d.ready    = 1'b1;
    st_d.pinSync1 = pinIn;
    st_d.pinSync2 = st_q.pinSync1;
    st_d.pinLast  = st_q.pinSync2;
    if (ctrlWr) begin
      st_d.unitOn    = ctrlNext[UNIT_ON_BIT];
      st_d.idleHalt  = ctrlNext[IDLE_HALT_BIT];
      st_d.debugHalt = ctrlNext[DEBUG_HALT_BIT];
    end
    if (!debugMode) begin
      st_d.debugHalt = 1'b0;
    end
    if (enWr) begin
      st_d.enable = enNext[PINS-1:0];
    end
    if (maskWr) begin
      st_d.mask = hwdata[PINS-1:0];
    end
    // A new change beats a simultaneous clear
    st_d.stat = (st_q.stat & ~statClr) | pinEvent;
    st_d.irq  = |(st_d.stat & st_d.mask);
    st_d.aphValid = aphTake;
    if (aphTake) begin
      st_d.aphWrite = hwrite;
      st_d.aphAddr  = haddr[OFS_W-1:0];
    end
    // Read data built from next state so a write just before is seen
    if (aphTake && !hwrite) begin
      st_d.rdata = readWord(haddr[OFS_W-1:0], st_d, debugMode);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q           <= '0;
      st_q.ready     <= 1'b1;
      st_q.unitOn    <= CTRL_RST[UNIT_ON_BIT];
      st_q.debugHalt <= CTRL_RST[DEBUG_HALT_BIT];
      st_q.idleHalt  <= CTRL_RST[IDLE_HALT_BIT];
      st_q.enable    <= EN_RST[PINS-1:0];
      st_q.mask      <= MASK_RST[PINS-1:0];
      st_q.stat      <= STAT_RST[PINS-1:0];
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    hreadyout = st_q.ready;
    hrdata    = st_q.rdata;
    hresp     = HRESP_OKAY;
    irq       = st_q.irq;
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic            ctrlRdData;
  logic            aliasRdData;
  logic            enRdData;
  logic [PINS-1:0] statRise;
  logic [PINS-1:0] setClrBoth;
  always_comb begin
    ctrlRdData  = st_q.aphValid & ~st_q.aphWrite
                & (st_q.aphAddr == CTRL_OFS);
    aliasRdData = st_q.aphValid & ~st_q.aphWrite
                & (inGroup(st_q.aphAddr, CTRL_OFS)
                   | inGroup(st_q.aphAddr, EN_OFS))
                & (st_q.aphAddr[3:2] != 2'b00);
    statRise    = st_d.stat & ~st_q.stat;
    enRdData    = st_q.aphValid & ~st_q.aphWrite
                & (st_q.aphAddr == EN_OFS);
    setClrBoth  = statClr & pinEvent;
  end

  debug_forced_zero_a : assert property (
    !$past(debugMode) |-> !st_q.debugHalt)
    else $error("halt-in-debug bit kept outside debug mode");

  debug_write_blocked_a : assert property (
    ctrlWr && !debugMode |=> !st_q.debugHalt)
    else $error("halt-in-debug bit written outside debug mode");

  debug_write_taken_a : assert property (
    ctrlWr && debugMode && wrOp == CNC_OP_SET && hwdata[DEBUG_HALT_BIT]
    |=> st_q.debugHalt)
    else $error("halt-in-debug bit not set by a write in debug mode");

  debug_read_zero_a : assert property (
    ctrlRdData && !$past(debugMode) |-> !hrdata[DEBUG_HALT_BIT])
    else $error("halt-in-debug bit read as one outside debug mode");

  ctrl_clear_a : assert property (
    ctrlWr && wrOp == CNC_OP_CLEAR && hwdata[UNIT_ON_BIT]
    |=> !st_q.unitOn)
    else $error("clear alias did not clear the on bit");

  ctrl_clear_keep_a : assert property (
    ctrlWr && wrOp == CNC_OP_CLEAR && !hwdata[IDLE_HALT_BIT]
    |=> st_q.idleHalt == $past(st_q.idleHalt))
    else $error("clear alias changed a bit written with zero");

  ctrl_set_a : assert property (
    ctrlWr && wrOp == CNC_OP_SET && hwdata[IDLE_HALT_BIT]
    |=> st_q.idleHalt)
    else $error("set alias did not set the idle bit");

  ctrl_set_keep_a : assert property (
    ctrlWr && wrOp == CNC_OP_SET && !hwdata[UNIT_ON_BIT]
    |=> st_q.unitOn == $past(st_q.unitOn))
    else $error("set alias changed a bit written with zero");

  ctrl_invert_a : assert property (
    ctrlWr && wrOp == CNC_OP_INVERT && hwdata[UNIT_ON_BIT]
    |=> st_q.unitOn != $past(st_q.unitOn))
    else $error("invert alias did not toggle the on bit");

  ctrl_invert_keep_a : assert property (
    ctrlWr && wrOp == CNC_OP_INVERT && !hwdata[IDLE_HALT_BIT]
    |=> st_q.idleHalt == $past(st_q.idleHalt))
    else $error("invert alias changed a bit written with zero");

  ctrl_reserved_a : assert property (
    ##1 ctrlRdData |-> hrdata[12:0] == '0 && hrdata[31:16] == '0)
    else $error("reserved control bits read nonzero");

  en_reserved_a : assert property (
    enRdData |-> hrdata[DATA_W-1:PINS] == '0)
    else $error("unimplemented enable bits read nonzero");

  alias_read_a : assert property (
    aliasRdData |-> hrdata == ALIAS_READ)
    else $error("alias read returned register contents");

  idle_stop_a : assert property (
    st_q.idleHalt && idleMode |-> statRise == '0)
    else $error("change flagged while stopped in idle");

  unit_off_a : assert property (
    !st_q.unitOn |-> statRise == '0)
    else $error("change flagged while unit switched off");

  unit_on_write_a : assert property (
    ctrlWr && wrOp == CNC_OP_WRITE
    |=> st_q.unitOn == $past(hwdata[UNIT_ON_BIT]))
    else $error("direct control write did not load the on bit");

  output_pin_a : assert property (
    (statRise & ~(pinDirection & st_q.enable)) == '0)
    else $error("change flagged for disabled or output pin");

  en_set_a : assert property (
    enWr && wrOp == CNC_OP_SET
    |=> (st_q.enable & $past(hwdata[PINS-1:0])) == $past(hwdata[PINS-1:0]))
    else $error("enable set alias did not set a written bit");

  en_clear_a : assert property (
    enWr && wrOp == CNC_OP_CLEAR
    |=> (st_q.enable & $past(hwdata[PINS-1:0])) == '0)
    else $error("enable clear alias left a written bit set");

  set_wins_a : assert property (
    setClrBoth != '0
    |=> (st_q.stat & $past(setClrBoth)) == $past(setClrBoth))
    else $error("status clear beat a simultaneous change");

  irq_level_a : assert property (
    irq == |(st_q.stat & st_q.mask))
    else $error("interrupt output disagrees with status and mask");

  okay_ready_a : assert property (
    hreadyout && hresp == HRESP_OKAY)
    else $error("slave stalled or answered with an error");

  set_on_c : cover property (
    ctrlWr && wrOp == CNC_OP_SET && hwdata[UNIT_ON_BIT] ##1 st_q.unitOn);

  pin_event_c : cover property (pinEvent != '0);

  irq_raise_c : cover property (!irq ##1 irq);

  set_beats_clear_c : cover property ((statClr & pinEvent) != '0);

  debug_halt_c : cover property (st_q.unitOn && st_q.debugHalt && debugMode);

endmodule
`default_nettype wire

// *** rtl/cnc_pkg.sv ***
`default_nettype none
package cnc_pkg;

  // Bus geometry
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int OFS_W     = 8;
  localparam int PIN_COUNT = 22;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CTRL_CLR_OFS = 8'h04;
  localparam logic [7:0] CTRL_SET_OFS = 8'h08;
  localparam logic [7:0] CTRL_INV_OFS = 8'h0c;
  localparam logic [7:0] EN_OFS       = 8'h10;
  localparam logic [7:0] EN_CLR_OFS   = 8'h14;
  localparam logic [7:0] EN_SET_OFS   = 8'h18;
  localparam logic [7:0] EN_INV_OFS   = 8'h1c;
  localparam logic [7:0] STAT_OFS     = 8'h20;
  localparam logic [7:0] MASK_OFS     = 8'h24;

  // Alias group decode: the low two word-address bits pick the operation
  localparam logic [7:0] GROUP_MASK = 8'hf3;

  // Control field positions
  localparam int UNIT_ON_BIT    = 15;
  localparam int DEBUG_HALT_BIT = 14;
  localparam int IDLE_HALT_BIT  = 13;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] EN_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;

  // Value returned for write-only aliases and unmapped offsets
  localparam logic [31:0] ALIAS_READ = 32'h0000_0000;

  // AHB encodings
  localparam int   HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY        = 1'b0;

  // Order follows the alias offsets within a group
  typedef enum logic [1:0] {
    CNC_OP_WRITE,
    CNC_OP_CLEAR,
    CNC_OP_SET,
    CNC_OP_INVERT
  } cnc_op_t;

endpackage
`default_nettype wire

// *** rtl/cnc_alias_update.sv ***
`timescale 1ns/1ps
`default_nettype none
module cnc_alias_update #(
  parameter int W = 32
) (
  // Current contents and the bits software may change
  input  wire logic            [W-1:0] cur,
  input  wire logic            [W-1:0] wmask,
  // Written word and the operation it carries
  input  wire logic            [W-1:0] wdata,
  input  wire cnc_pkg::cnc_op_t        op,
  // Resulting contents
  output logic                 [W-1:0] nxt
);
  import cnc_pkg::*;

  logic [W-1:0] raw;

  always_comb begin
    case (op)
      CNC_OP_WRITE:  raw = wdata;
      CNC_OP_CLEAR:  raw = cur & ~wdata;
      CNC_OP_SET:    raw = cur | wdata;
      CNC_OP_INVERT: raw = cur ^ wdata;
      default:       raw = cur;
    endcase
    // Unimplemented and read-only bits keep their value
    nxt = (cur & ~wmask) | (raw & wmask);
  end

endmodule
`default_nettype wire

// *** dv/cnc_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cnc_regs_tb;
  import cnc_pkg::*;

  logic        core_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        debugMode;
  logic        idleMode;
  logic [21:0] pinIn;
  logic [21:0] pinDirection;
  logic        irq;
  int          fails;
  int          checks;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  cnc_regs cnc_regs_inst (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hrdata       (hrdata),
    .hresp        (hresp),
    .debugMode    (debugMode),
    .idleMode     (idleMode),
    .pinIn        (pinIn),
    .pinDirection (pinDirection),
    .irq          (irq)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic end_sim;
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for a rising edge with ready high, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fails++;
      $display("BAD t=%0t bus hung", $time);
      end_sim();
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(a, 1'b1, d, dummy);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(a, 1'b0, 32'h0000_0000, d);
    chk(d, e);
  endtask

  // Toggles one pin, lets the synchroniser and status flop settle
  task automatic flip(input int p);
    @(posedge core_clk);
    pinIn[p] <= ~pinIn[p];
    repeat (5) @(posedge core_clk);
  endtask

  task automatic clear_stat(input logic [31:0] e);
    rdchk(STAT_OFS, e);
    wr(STAT_OFS, e);
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    debugMode = 1'b0;
    idleMode = 1'b0;
    pinIn = 22'h00_0000;
    pinDirection = 22'h3f_ffff;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk(CTRL_OFS, CTRL_RST);
    rdchk(EN_OFS, EN_RST);
    rdchk(MASK_OFS, MASK_RST);
    rdchk(STAT_OFS, STAT_RST);
    rdchk(8'h40, ALIAS_READ);
    wr(CTRL_OFS, 32'hffff_ffff);
    rdchk(CTRL_OFS, 32'h0000_a000);
    wr(CTRL_CLR_OFS, 32'h0000_8000);
    rdchk(CTRL_OFS, 32'h0000_2000);
    wr(CTRL_SET_OFS, 32'hffff_ffff);
    rdchk(CTRL_OFS, 32'h0000_a000);
    wr(CTRL_INV_OFS, 32'hffff_ffff);
    rdchk(CTRL_OFS, 32'h0000_0000);
    wr(CTRL_INV_OFS, 32'h0000_8000);
    rdchk(CTRL_OFS, 32'h0000_8000);
    for (int i = 1; i < 8; i++) begin
      if (i != 4) begin
        rdchk(8'(4 * i), ALIAS_READ);
      end
    end
    wr(CTRL_SET_OFS, 32'h0000_4000);
    rdchk(CTRL_OFS, 32'h0000_8000);
    debugMode <= 1'b1;
    wr(CTRL_SET_OFS, 32'h0000_4000);
    rdchk(CTRL_OFS, 32'h0000_c000);
    debugMode <= 1'b0;
    @(posedge core_clk);
    rdchk(CTRL_OFS, 32'h0000_8000);
    wr(EN_OFS, 32'hffff_ffff);
    rdchk(EN_OFS, 32'h003f_ffff);
    wr(EN_CLR_OFS, 32'h0000_8001);
    rdchk(EN_OFS, 32'h003f_7ffe);
    wr(EN_SET_OFS, 32'h0000_8001);
    rdchk(EN_OFS, 32'h003f_ffff);
    wr(EN_INV_OFS, 32'hffc0_0003);
    rdchk(EN_OFS, 32'h003f_fffc);
    wr(EN_OFS, 32'h0000_0007);
    wr(MASK_OFS, 32'h0000_0001);
    flip(0);
    chk(32'(irq), 32'h1);
    clear_stat(32'h0000_0001);
    chk(32'(irq), 32'h0);
    flip(1);
    chk(32'(irq), 32'h0);
    clear_stat(32'h0000_0002);
    pinDirection[2] <= 1'b0;
    flip(2);
    rdchk(STAT_OFS, 32'h0000_0000);
    wr(CTRL_CLR_OFS, 32'h0000_8000);
    flip(0);
    rdchk(STAT_OFS, 32'h0000_0000);
    wr(CTRL_SET_OFS, 32'h0000_a000);
    idleMode <= 1'b1;
    flip(0);
    rdchk(STAT_OFS, 32'h0000_0000);
    idleMode <= 1'b0;
    flip(0);
    clear_stat(32'h0000_0001);
    debugMode <= 1'b1;
    wr(CTRL_SET_OFS, 32'h0000_4000);
    flip(0);
    rdchk(STAT_OFS, 32'h0000_0000);
    debugMode <= 1'b0;
    flip(0);
    clear_stat(32'h0000_0001);
    flip(0);
    chk(32'(irq), 32'h1);
    // Reset in mid-run drops the interrupt and restores the control, enable and status registers
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdchk(CTRL_OFS, CTRL_RST);
    rdchk(EN_OFS, EN_RST);
    rdchk(STAT_OFS, STAT_RST);
    chk(32'(hresp), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
